/* include/pwc_pkg.sv */
// constants and types of the four-channel pulse and capture unit
package pwc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTL = 8'h00;
	localparam logic [7:0] OFS_PRESCALE = 8'h04;
	localparam logic [7:0] OFS_DEAD = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CAPCTL = 8'h14;
	localparam logic [7:0] OFS_CAPIE = 8'h18;
	localparam logic [7:0] OFS_BUF = 8'h20;
	localparam logic [7:0] OFS_RISE = 8'h30;
	localparam logic [7:0] OFS_FALL = 8'h40;
	localparam logic [7:0] OFS_CNT = 8'h50;
	// writable bits of each register
	localparam logic [31:0] CTL_WMASK = 32'h0000_ff3f;
	localparam logic [31:0] PRESCALE_WMASK = 32'h0077_ffff;
	localparam logic [31:0] DEAD_WMASK = 32'h0000_ffff;
	localparam logic [31:0] MASK_WMASK = 32'h0000_000f;
	localparam logic [31:0] CAPCTL_WMASK = 32'h0000_004f;
	localparam logic [31:0] CAPIE_WMASK = 32'h0000_00ff;
	// field positions
	localparam int CTL_PAIR01_BIT = 4;
	localparam int CTL_PAIR23_BIT = 5;
	localparam int CTL_CONT_LSB = 8;
	localparam int CTL_CENTER_LSB = 12;
	localparam int PRE_DIV_LSB = 16;
	localparam int CAP_RELOAD0_BIT = 6;
	localparam int STAT_RISE_LSB = 4;
	localparam int STAT_FALL_LSB = 8;
	localparam logic [2:0] DIV_SEL_MAX = 3'h4;
	// reset values
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [11:0] STATUS_RESET = 12'h000;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [31:0] ctl;
		logic [31:0] prescale;
		logic [31:0] dead;
		logic [31:0] mask;
		logic [31:0] capctl;
		logic [31:0] capie;
		logic [11:0] status;
		logic [3:0][31:0] buffer;
		logic [3:0][15:0] period;
		logic [3:0][15:0] duty;
		logic [3:0][15:0] cnt;
		logic [3:0] dir_up;
		logic [3:0] active;
		logic [3:0] stopped;
		logic [3:0] raw;
		logic [3:0] cap_meta;
		logic [3:0] cap_sync;
		logic [3:0] cap_prev;
		logic [3:0][15:0] rise;
		logic [3:0][15:0] fall;
		logic [1:0][7:0] pre_cnt;
		logic [1:0][3:0] div_cnt;
		logic [1:0][7:0] dz_cnt;
		logic [1:0] gov_prev;
		logic [3:0] pin;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} pwc_state_t;
endpackage : pwc_pkg

/* src/pwc_top.sv */
// four-channel pulse generator with capture, axi4-lite registers
//
// What this block does
// - four outputs, independent or paired 0/1 and 2/3 with dead-zone.
// - each pair shares 8-bit prescaler then divider 1, 1/2, 1/4, 1/8, 1/16.
// - per-channel 16-bit counter, down in edge mode, up-down in center.
// - per-channel 16-bit compare; output changes level on counter match.
// - four period flags, set when the channel counter reaches zero.
// - interrupt high only while a flag and its enable are both set.
// - one-shot mode runs one period, stops at zero, one request.
// - continuous mode reloads period at zero and keeps counting.
// - pair bit 4 pairs channels 0 and 1, timed by channel 0.
// - pair bit 5 pairs channels 2 and 3, timed by channel 2.
// - period and compare writes buffered, taken into use at zero.
// - capture enable turns the pin into an input sharing the counter.
// - rising edge latches counter to rising latch, falling to falling latch.
// - channel 0 capture interrupt enabled by bit 0 rising, bit 1 falling.
// - reload bit 6 reloads channel 0 counter on a rising capture.
// - status bits clear on write of one, zeros ignored.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pwc_top (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// channel pins
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	// interrupt
	output logic irq
);
	pwc_pkg::pwc_state_t s_q;
	pwc_pkg::pwc_state_t s_d;
	logic [3:0] zero_ev;
	logic [3:0] rise_ev;
	logic [11:0] st_set;
	logic [11:0] st_clr;
	logic [1:0] tick;
	logic wr_go;
	logic rd_go;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb,
		input logic [31:0] wmask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = val[8*b +: 8];
			end
		end
		return res & wmask;
	endfunction : merge

	function automatic logic [3:0] div_mask(input logic [2:0] sel);
		logic [2:0] c;
		c = (sel > pwc_pkg::DIV_SEL_MAX) ? pwc_pkg::DIV_SEL_MAX : sel;
		return 4'((5'h01 << c) - 5'h01);
	endfunction : div_mask

	function automatic logic [31:0] read_mux(pwc_pkg::pwc_state_t s,
		input logic [7:0] a, output logic ok);
		logic [31:0] v;
		logic [7:0] hi;
		v = 32'h0000_0000;
		ok = 1'b1;
		hi = {a[7:4], 4'h0};
		if (hi == pwc_pkg::OFS_BUF) begin
			v = s.buffer[a[3:2]];
		end else if (hi == pwc_pkg::OFS_RISE) begin
			v = {16'h0000, s.rise[a[3:2]]};
		end else if (hi == pwc_pkg::OFS_FALL) begin
			v = {16'h0000, s.fall[a[3:2]]};
		end else if (hi == pwc_pkg::OFS_CNT) begin
			v = {16'h0000, s.cnt[a[3:2]]};
		end else begin
			unique case ({a[7:2], 2'h0})
				pwc_pkg::OFS_CTL: v = s.ctl;
				pwc_pkg::OFS_PRESCALE: v = s.prescale;
				pwc_pkg::OFS_DEAD: v = s.dead;
				pwc_pkg::OFS_MASK: v = s.mask;
				pwc_pkg::OFS_STATUS: v = {20'h00000, s.status};
				pwc_pkg::OFS_CAPCTL: v = s.capctl;
				pwc_pkg::OFS_CAPIE: v = s.capie;
				default: ok = 1'b0;
			endcase
		end
		return v;
	endfunction : read_mux

	always_comb begin
		logic [7:0] hi;
		logic [31:0] rv;
		logic rok;
		logic en;
		logic cont;
		logic center;
		logic pair;
		logic g;
		logic done;
		logic cap_rel;
		logic [31:0] clr_w;
		int p;
		hi = 8'h00;
		rv = 32'h0000_0000;
		rok = 1'b0;
		en = 1'b0;
		cont = 1'b0;
		center = 1'b0;
		pair = 1'b0;
		g = 1'b0;
		done = 1'b0;
		cap_rel = 1'b0;
		clr_w = 32'h0000_0000;
		p = 0;
		s_d = s_q;
		zero_ev = 4'h0;
		rise_ev = 4'h0;
		st_set = 12'h000;
		st_clr = 12'h000;
		tick = 2'h0;
		// bus write: address and data taken together
		wr_go = awvalid & wvalid & ~s_q.bvalid & ce;
		hi = {awaddr[7:4], 4'h0};
		if (wr_go) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = pwc_pkg::RESP_OKAY;
			if (hi == pwc_pkg::OFS_BUF) begin
				s_d.buffer[awaddr[3:2]] = merge(s_q.buffer[awaddr[3:2]],
					wdata, wstrb, 32'hffff_ffff);
			end else begin
				unique case ({awaddr[7:2], 2'h0})
					pwc_pkg::OFS_CTL: s_d.ctl = merge(s_q.ctl, wdata, wstrb,
						pwc_pkg::CTL_WMASK);
					pwc_pkg::OFS_PRESCALE: s_d.prescale = merge(s_q.prescale,
						wdata, wstrb, pwc_pkg::PRESCALE_WMASK);
					pwc_pkg::OFS_DEAD: s_d.dead = merge(s_q.dead, wdata,
						wstrb, pwc_pkg::DEAD_WMASK);
					pwc_pkg::OFS_MASK: s_d.mask = merge(s_q.mask, wdata,
						wstrb, pwc_pkg::MASK_WMASK);
					pwc_pkg::OFS_STATUS: begin
						clr_w = merge(32'h0000_0000, wdata, wstrb,
							32'h0000_0fff);
						st_clr = clr_w[11:0];
					end
					pwc_pkg::OFS_CAPCTL: s_d.capctl = merge(s_q.capctl,
						wdata, wstrb, pwc_pkg::CAPCTL_WMASK);
					pwc_pkg::OFS_CAPIE: s_d.capie = merge(s_q.capie, wdata,
						wstrb, pwc_pkg::CAPIE_WMASK);
					default: s_d.bresp = pwc_pkg::RESP_SLVERR;
				endcase
			end
		end else if (s_q.bvalid & bready) begin
			s_d.bvalid = 1'b0;
		end
		// bus read
		rd_go = arvalid & ~s_q.rvalid & ce;
		rv = read_mux(s_q, araddr, rok);
		if (rd_go) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rv;
			s_d.rresp = rok ? pwc_pkg::RESP_OKAY : pwc_pkg::RESP_SLVERR;
		end else if (s_q.rvalid & rready) begin
			s_d.rvalid = 1'b0;
		end
		// per-pair prescaler and divider
		for (int k = 0; k < 2; k++) begin
			if (s_q.pre_cnt[k] == s_q.prescale[8*k +: 8]) begin
				s_d.pre_cnt[k] = 8'h00;
				s_d.div_cnt[k] = s_q.div_cnt[k] + 4'h1;
				tick[k] = ce & ((s_q.div_cnt[k] & div_mask(
					s_q.prescale[pwc_pkg::PRE_DIV_LSB + 4*k +: 3]))
					== div_mask(s_q.prescale[pwc_pkg::PRE_DIV_LSB + 4*k +: 3]));
			end else begin
				s_d.pre_cnt[k] = s_q.pre_cnt[k] + 8'h01;
			end
		end
		// channels
		for (int n = 0; n < 4; n++) begin
			p = n / 2;
			en = s_q.ctl[n];
			cont = s_q.ctl[pwc_pkg::CTL_CONT_LSB + n];
			center = s_q.ctl[pwc_pkg::CTL_CENTER_LSB + n];
			cap_rel = 1'b0;
			// pin synchroniser and capture
			s_d.cap_meta[n] = pin_in[n];
			s_d.cap_sync[n] = s_q.cap_meta[n];
			s_d.cap_prev[n] = s_q.cap_sync[n];
			if (s_q.capctl[n]) begin
				if (s_q.cap_sync[n] & ~s_q.cap_prev[n]) begin
					rise_ev[n] = 1'b1;
					s_d.rise[n] = s_q.cnt[n];
					st_set[pwc_pkg::STAT_RISE_LSB + n] = 1'b1;
					cap_rel = (n == 0) &
						s_q.capctl[pwc_pkg::CAP_RELOAD0_BIT];
				end
				if (~s_q.cap_sync[n] & s_q.cap_prev[n]) begin
					s_d.fall[n] = s_q.cnt[n];
					st_set[pwc_pkg::STAT_FALL_LSB + n] = 1'b1;
				end
			end
			// counter
			if (!en) begin
				s_d.active[n] = 1'b0;
				s_d.stopped[n] = 1'b0;
				s_d.raw[n] = 1'b0;
			end else if (!s_q.active[n] && !s_q.stopped[n]) begin
				s_d.active[n] = 1'b1;
				s_d.period[n] = s_q.buffer[n][15:0];
				s_d.duty[n] = s_q.buffer[n][31:16];
				s_d.cnt[n] = center ? 16'h0000 : s_q.buffer[n][15:0];
				s_d.dir_up[n] = center;
				s_d.raw[n] = 1'b0;
			end else if (s_q.active[n] && cap_rel) begin
				s_d.cnt[n] = center ? 16'h0000 : s_q.period[n];
				s_d.dir_up[n] = center;
				s_d.raw[n] = 1'b0;
			end else if (s_q.active[n] && tick[p]) begin
				if (!s_q.dir_up[n] && s_q.cnt[n] == 16'h0000) begin
					zero_ev[n] = 1'b1;
					st_set[n] = 1'b1;
					s_d.period[n] = s_q.buffer[n][15:0];
					s_d.duty[n] = s_q.buffer[n][31:16];
					s_d.raw[n] = 1'b0;
					if (!cont) begin
						s_d.active[n] = 1'b0;
						s_d.stopped[n] = 1'b1;
					end else if (center) begin
						s_d.dir_up[n] = 1'b1;
					end else begin
						s_d.cnt[n] = s_q.buffer[n][15:0];
					end
				end else begin
					if (s_q.dir_up[n]) begin
						if (s_q.cnt[n] >= s_q.period[n]) begin
							s_d.dir_up[n] = 1'b0;
							s_d.cnt[n] = (s_q.cnt[n] == 16'h0000) ? 16'h0000
								: s_q.cnt[n] - 16'h0001;
						end else begin
							s_d.cnt[n] = s_q.cnt[n] + 16'h0001;
						end
					end else begin
						s_d.cnt[n] = s_q.cnt[n] - 16'h0001;
					end
					if (s_q.cnt[n] == s_q.duty[n]) begin
						s_d.raw[n] = ~s_q.raw[n];
					end
				end
			end
		end
		// status: a set in the same cycle beats the clear
		s_d.status = (s_q.status & ~st_clr) | st_set;
		// dead-zone generators and pin drive
		for (int k = 0; k < 2; k++) begin
			pair = s_q.ctl[pwc_pkg::CTL_PAIR01_BIT + k];
			g = s_q.raw[2*k];
			s_d.gov_prev[k] = g;
			if (g != s_q.gov_prev[k]) begin
				s_d.dz_cnt[k] = s_q.dead[8*k +: 8];
			end else if (s_q.dz_cnt[k] != 8'h00) begin
				s_d.dz_cnt[k] = s_q.dz_cnt[k] - 8'h01;
			end
			done = (g == s_q.gov_prev[k]) && (s_q.dz_cnt[k] == 8'h00) &&
				s_q.ctl[2*k];
			if (pair) begin
				s_d.pin[2*k] = g & done;
				s_d.pin[2*k+1] = ~g & done;
			end else begin
				s_d.pin[2*k] = s_q.raw[2*k];
				s_d.pin[2*k+1] = s_q.raw[2*k+1];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// handshakes and outputs
	assign awready = awvalid & wvalid & ~s_q.bvalid & ce;
	assign wready = awvalid & wvalid & ~s_q.bvalid & ce;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = ~s_q.rvalid & ce;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
	assign pin_out = s_q.pin;
	assign pin_oe = ~s_q.capctl[3:0];
	always_comb begin
		logic [7:0] cap_en;
		cap_en = 8'h00;
		for (int n = 0; n < 4; n++) begin
			cap_en[n] = s_q.capie[2*n];
			cap_en[4+n] = s_q.capie[2*n+1];
		end
		irq = |(s_q.status & {cap_en[7:4], cap_en[3:0], s_q.mask[3:0]});
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_zero_sets_flag: assert property (zero_ev[0] |=> s_q.status[0])
		else $error("zero reach did not set flag");
	a_oneshot_stops: assert property (
		zero_ev[0] && !s_q.ctl[pwc_pkg::CTL_CONT_LSB] && s_q.ctl[0]
		|=> !s_q.active[0] ##1 (!s_q.active[0] || !s_q.ctl[0]))
		else $error("one-shot channel kept running");
	a_cont_reload: assert property (
		zero_ev[0] && s_q.ctl[pwc_pkg::CTL_CONT_LSB]
		&& !s_q.ctl[pwc_pkg::CTL_CENTER_LSB] && !rise_ev[0]
		|=> s_q.cnt[0] == $past(s_q.buffer[0][15:0]))
		else $error("continuous reload missing");
	a_buffer_held: assert property (
		ce && s_q.active[2] && !zero_ev[2] && s_q.ctl[2]
		|=> $stable(s_q.period[2]) && $stable(s_q.duty[2]))
		else $error("active values changed away from zero");
	a_rise_latch: assert property (
		ce && rise_ev[0] |=> s_q.rise[0] == $past(s_q.cnt[0])
		&& s_q.status[pwc_pkg::STAT_RISE_LSB])
		else $error("rising capture not latched");
	a_w1c_clear: assert property (
		ce && (st_clr & ~st_set & s_q.status) != 12'h000
		|=> (s_q.status & $past(st_clr & ~st_set)) == 12'h000)
		else $error("write one did not clear status");
	a_dead_gap: assert property (
		ce && s_q.ctl[pwc_pkg::CTL_PAIR01_BIT] && s_q.raw[0] != s_q.gov_prev[0]
		|=> ##1 !s_q.pin[0] && !s_q.pin[1])
		else $error("paired outputs overlap in dead time");
	a_pair_compl: assert property (
		ce && s_q.ctl[pwc_pkg::CTL_PAIR23_BIT] && s_q.pin[2]
		|-> !s_q.pin[3])
		else $error("pair outputs both high");
	a_cap_reload: assert property (
		rise_ev[0] && s_q.active[0] && s_q.capctl[pwc_pkg::CAP_RELOAD0_BIT]
		&& !s_q.ctl[pwc_pkg::CTL_CENTER_LSB] && s_q.ctl[0]
		|=> s_q.cnt[0] == $past(s_q.period[0]))
		else $error("capture reload missed");
	a_bresp_hold: assert property (
		s_q.bvalid && !bready |=> s_q.bvalid && $stable(s_q.bresp))
		else $error("write response dropped");

	c_period_wrap: cover property (zero_ev[0] ##[1:200] zero_ev[0]);
	c_capture_both: cover property (rise_ev[0] ##[1:200] s_q.status[8]);
	c_irq_raised: cover property ($rose(irq));
endmodule : pwc_top

/* verif/pwc_pins.sv */
// pin-side model: capture signal source and paired output watcher
`timescale 1ns/1ps
module pwc_pins (
	// clock
	input wire logic aclk,
	// unit pins
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	output logic [3:0] pin_in,
	// capture source from the bench
	input wire logic [3:0] src,
	// pair watch
	input wire logic arm,
	output int overlap,
	output int min_gap
);
	int low [2] = '{0, 0};
	int ovl = 0;
	int gap = 255;
	// the unit drives while enabled, otherwise the source drives
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & src);
	assign overlap = ovl;
	assign min_gap = gap;
	// both outputs of a pair never high, both low before a rise
	always @(posedge aclk) begin
		for (int p = 0; p < 2; p++) begin
			if (arm && pin_out[2*p] && pin_out[2*p+1]) begin
				ovl <= ovl + 1;
			end
			if (pin_out[2*p] || pin_out[2*p+1]) begin
				if (arm && low[p] > 0 && low[p] < gap) begin
					gap <= low[p];
				end
				low[p] <= 0;
			end else begin
				low[p] <= low[p] + 1;
			end
		end
	end
endmodule : pwc_pins

/* verif/tb.sv */
// self-checking bench of the pulse and capture unit
`timescale 1ns/1ps
module tb;
	logic aclk = 1'h0, aresetn = 1'h0, arm = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, seed = 32'h590214d8;
	logic [3:0] src = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] pin_in, pin_out, pin_oe;
	logic [31:0] rdata, rd_v, d;
	int n_errors = 0, comparisons = 0, cyc = 0;
	int overlap, min_gap, t0, hi;

	always #12.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	pwc_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .irq(irq));
	pwc_pins pins (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_in(pin_in), .src(src), .arm(arm), .overlap(overlap),
		.min_gap(min_gap));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// zero interval doubles with each divider step
	function automatic int scaled(input int b, input int s);
		return b << s;
	endfunction : scaled

	task automatic final_report;
		if (n_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for one handshake or the interrupt
	task automatic hold(input int k);
		for (int i = 0; i < 5000; i++) begin
			@(posedge aclk);
			if ((k == 0 && awready === 1'h1) || (k == 1 && bvalid === 1'h1)
				|| (k == 2 && arready === 1'h1) || (k == 3 && rvalid === 1'h1)
				|| (k == 4 && irq === 1'h1))
				return;
		end
		n_errors++;
		final_report;
	endtask : hold
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		awaddr <= a;
		wdata <= v;
		bready <= 1'h1;
		hold(0);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		hold(1);
		bready <= 1'h0;
		rs = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		hold(2);
		arvalid <= 1'h0;
		hold(3);
		rready <= 1'h0;
		rd_v = rdata;
		rs = rresp;
	endtask : rd

	initial begin
		#(25 * 100000);
		n_errors++;
		final_report;
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk(32'(pin_oe), 32'hf);
		chk(32'(irq), 32'h0);
		rd(pwc_pkg::OFS_STATUS);
		chk(rd_v, 32'h0);
		rd(8'h1c);
		chk(32'(rs), 32'(pwc_pkg::RESP_SLVERR));
		wr(pwc_pkg::OFS_CNT, rnd());
		chk(32'(rs), 32'(pwc_pkg::RESP_SLVERR));
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			wr(pwc_pkg::OFS_DEAD, d);
			rd(pwc_pkg::OFS_DEAD);
			chk(rd_v, d & pwc_pkg::DEAD_WMASK);
		end
		// one-shot channel 0
		wr(pwc_pkg::OFS_BUF, {16'h000a, 16'h0014});
		wr(pwc_pkg::OFS_MASK, 32'h1);
		wr(pwc_pkg::OFS_CTL, 32'h1);
		hold(4);
		rd(pwc_pkg::OFS_STATUS);
		chk(rd_v & 32'h1, 32'h1);
		wr(pwc_pkg::OFS_MASK, 32'h0);
		chk(32'(irq), 32'h0);
		wr(pwc_pkg::OFS_STATUS, 32'h0);
		rd(pwc_pkg::OFS_STATUS);
		chk(rd_v & 32'h1, 32'h1);
		wr(pwc_pkg::OFS_STATUS, 32'h1);
		repeat (100) @(posedge aclk);
		rd(pwc_pkg::OFS_STATUS);
		chk(rd_v & 32'h1, 32'h0);
		rd(pwc_pkg::OFS_CNT);
		chk(rd_v, 32'h0);
		// continuous mode over every divider setting
		d = 32'h0004_0010 | (rnd() & 32'h0000_000f);
		hi = 2 * (int'(d[15:0]) + 1);
		wr(pwc_pkg::OFS_BUF, d);
		wr(pwc_pkg::OFS_MASK, 32'h1);
		for (int s = 0; s < 5; s++) begin
			wr(pwc_pkg::OFS_CTL, 32'h0);
			wr(pwc_pkg::OFS_STATUS, 32'hfff);
			wr(pwc_pkg::OFS_PRESCALE, 32'(s) << pwc_pkg::PRE_DIV_LSB | 32'h1);
			wr(pwc_pkg::OFS_CTL, 32'h101);
			hold(4);
			t0 = cyc;
			wr(pwc_pkg::OFS_STATUS, 32'h1);
			hold(4);
			chk(32'(cyc - t0), 32'(scaled(hi, s)));
		end
		// center-aligned: up then down, 2P+1 ticks between zeros
		wr(pwc_pkg::OFS_CTL, 32'h0);
		wr(pwc_pkg::OFS_STATUS, 32'hfff);
		wr(pwc_pkg::OFS_PRESCALE, 32'h1);
		wr(pwc_pkg::OFS_CTL, 32'h1101);
		hold(4);
		t0 = cyc;
		wr(pwc_pkg::OFS_STATUS, 32'h1);
		hold(4);
		chk(32'(cyc - t0), 32'(4 * int'(d[15:0]) + 2));
		// buffered period taken only at zero
		wr(pwc_pkg::OFS_CTL, 32'h0);
		wr(pwc_pkg::OFS_PRESCALE, 32'h0);
		wr(pwc_pkg::OFS_BUF, {16'h0005, 16'h001e});
		wr(pwc_pkg::OFS_CTL, 32'h101);
		wr(pwc_pkg::OFS_BUF, {16'h0005, 16'h0258});
		rd(pwc_pkg::OFS_CNT);
		chk(32'(rd_v <= 32'd30), 32'h1);
		wr(pwc_pkg::OFS_STATUS, 32'hfff);
		hold(4);
		rd(pwc_pkg::OFS_CNT);
		chk(32'(rd_v > 32'd30), 32'h1);
		// capture on channel 0, counter already running
		repeat (100) @(posedge aclk);
		wr(pwc_pkg::OFS_MASK, 32'h0);
		wr(pwc_pkg::OFS_CAPIE, 32'h1);
		wr(pwc_pkg::OFS_STATUS, 32'hfff);
		wr(pwc_pkg::OFS_CAPCTL, 32'h41);
		chk(32'(pin_oe), 32'he);
		src <= 4'h1;
		repeat (8) @(posedge aclk);
		chk(32'(irq), 32'h1);
		rd(pwc_pkg::OFS_STATUS);
		chk(rd_v & 32'h110, 32'h10);
		rd(pwc_pkg::OFS_CNT);
		chk(32'(rd_v >= 32'd580), 32'h1);
		rd(pwc_pkg::OFS_RISE);
		chk(32'(rd_v > 32'd300 && rd_v < 32'd600), 32'h1);
		wr(pwc_pkg::OFS_CAPIE, 32'h0);
		chk(32'(irq), 32'h0);
		wr(pwc_pkg::OFS_CAPIE, 32'h2);
		src <= 4'h0;
		repeat (8) @(posedge aclk);
		chk(32'(irq), 32'h1);
		rd(pwc_pkg::OFS_STATUS);
		chk(rd_v & 32'h100, 32'h100);
		// complementary pairs with dead time
		wr(pwc_pkg::OFS_CAPCTL, 32'h0);
		wr(pwc_pkg::OFS_DEAD, 32'h0404);
		for (int p = 0; p < 2; p++) begin
			wr(pwc_pkg::OFS_CTL, 32'h0);
			wr(pwc_pkg::OFS_BUF + 8'(8 * p), {16'h000a, 16'h001e});
			wr(pwc_pkg::OFS_CTL, (32'h1 << (2 * p)) | (32'h10 << p)
				| (32'h100 << (2 * p)));
			arm <= 1'h1;
			hi = 0;
			repeat (300) begin
				@(posedge aclk);
				hi = hi + int'(pin_out[2*p+1] === 1'h1);
			end
			arm <= 1'h0;
			chk(32'(hi > 0), 32'h1);
		end
		chk(32'(overlap), 32'h0);
		chk(32'(min_gap >= 4), 32'h1);
		final_report;
	end
endmodule : tb
